/* common/ssr_regs.vh */
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// register selects on the query/command port
`define SSR_SEL_OPER_COND 4'h0
`define SSR_SEL_OPER_RISE 4'h1
`define SSR_SEL_OPER_FALL 4'h2
`define SSR_SEL_OPER_EVENT 4'h3
`define SSR_SEL_OPER_ENABLE 4'h4
`define SSR_SEL_QUES_COND 4'h5
`define SSR_SEL_QUES_RISE 4'h6
`define SSR_SEL_QUES_FALL 4'h7
`define SSR_SEL_QUES_EVENT 4'h8
`define SSR_SEL_QUES_ENABLE 4'h9
`define SSR_SEL_ESR 4'hA
`define SSR_SEL_ESE 4'hB
`define SSR_SEL_STB 4'hC
`define SSR_SEL_SRE 4'hD
// group field layout and reset / preset values
`define SSR_GRP_USED 16'h7FFF
`define SSR_RISE_PRESET 16'hFFFF
`define SSR_FALL_PRESET 16'h0000
`define SSR_ENABLE_PRESET 16'h0000
`define SSR_BYTE_RESET 8'h00
// summary status byte bit positions
`define SSR_STB_ERRQ 2
`define SSR_STB_QUES 3
`define SSR_STB_MAV 4
`define SSR_STB_ESB 5
`define SSR_STB_MSS 6
`define SSR_STB_OPER 7
// standard event status bit positions and used mask
`define SSR_ESR_OPC 0
`define SSR_ESR_QRY 2
`define SSR_ESR_DEV 3
`define SSR_ESR_EXE 4
`define SSR_ESR_CMD 5
`define SSR_ESR_USED 8'h3D
// error code class bounds, signed 16-bit
`define SSR_QRY_LO 16'hFE0D
`define SSR_QRY_HI 16'hFE70
`define SSR_DEV_LO 16'hFE71
`define SSR_DEV_HI 16'hFED4
`define SSR_EXE_LO 16'hFED5
`define SSR_EXE_HI 16'hFF38
`define SSR_CMD_LO 16'hFF39
`define SSR_CMD_HI 16'hFF9C
`define SSR_DEVP_LO 16'h0001
`define SSR_DEVP_HI 16'h7FFF
// cycles after reset release before the saved language is taken
`define SSR_BOOT_WAIT 2'h3
`endif

/* rtl/ssr_group.v */
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.vh"
module ssr_group (
   input wire i_clk,
   input wire i_srst,
   input wire [15:0] i_cond,
   input wire i_wr_rise,
   input wire i_wr_fall,
   input wire i_wr_enable,
   input wire [15:0] i_wdata,
   input wire i_rd_event,
   input wire i_cls,
   input wire i_preset,
   output reg [15:0] o_rise,
   output reg [15:0] o_fall,
   output reg [15:0] o_event,
   output reg [15:0] o_enable,
   output wire o_summary
);
   reg [15:0] prev;
   reg prev_ok;
   wire [15:0] up_edge;
   wire [15:0] down_edge;
   wire [15:0] hit;

   // filtered transitions; no edge until a first sample is held
   assign up_edge = i_cond & ~prev & o_rise;
   assign down_edge = ~i_cond & prev & o_fall;
   assign hit = (up_edge | down_edge) & `SSR_GRP_USED & {16{prev_ok}};
   assign o_summary = |(o_event & o_enable);

   // previous condition sample for edge detection
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         prev <= 16'h0000;
         prev_ok <= 1'b0;
      end
      else
      begin
         prev <= i_cond;
         prev_ok <= 1'b1;
      end
   end

   // sticky events; a new edge wins over a query or clear
   always @(posedge i_clk)
   begin
      if (i_srst)
         o_event <= 16'h0000;
      else if (i_rd_event || i_cls)
         o_event <= hit;
      else
         o_event <= o_event | hit;
   end

   // filters and enable: preset loads, clear-status leaves alone
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rise <= `SSR_RISE_PRESET;
         o_fall <= `SSR_FALL_PRESET;
         o_enable <= `SSR_ENABLE_PRESET;
      end
      else if (i_preset)
      begin
         o_rise <= `SSR_RISE_PRESET;
         o_fall <= `SSR_FALL_PRESET;
         o_enable <= `SSR_ENABLE_PRESET;
      end
      else
      begin
         if (i_wr_rise)
            o_rise <= i_wdata & `SSR_GRP_USED;
         if (i_wr_fall)
            o_fall <= i_wdata & `SSR_GRP_USED;
         if (i_wr_enable)
            o_enable <= i_wdata & `SSR_GRP_USED;
      end
   end
endmodule // ssr_group
`default_nettype wire

/* rtl/ssr_status.v */
// Overview of operation
// - condition registers follow live status; reading never alters them.
// - falling filter catches 1-to-0, rising filter 0-to-1, both catch any change.
// - filters are read-write and survive queries, clear-status and reset command.
// - status preset zeroes falling filters and enables, sets rising filters to ones.
// - event bits latch until queried or clear-status; host cannot write them.
// - summary bit is OR of event AND enable; enables read-write, query-safe.
// - summary byte bits 0 and 1 always read zero.
// - summary bit 2 set while the error queue holds an entry.
// - summary bit 3 follows the questionable group summary.
// - summary bit 4 set while the output queue holds response data.
// - summary bit 5 follows the standard event group summary.
// - bit 6 is OR of byte bits ANDed with service request enable bits.
// - summary bit 7 follows the operational group summary.
// - standard event bit 0 sets when pending work ends after operation-complete.
// - standard event bit 2 sets on error codes -499 through -400.
// - bit 3 sets on codes -399 through -300 or 1 through 32767.
// - standard event bit 4 sets on error codes -299 through -200.
// - standard event bit 5 sets on error codes -199 through -100.
// - standard event bits 1, 6 and 7 always read zero.
// - only short uncoloned language command selects; other forms are syntax errors.
// - under the new language a power cycle returns the instrument to reset.
// - querying the standard event register returns it and clears it.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.vh"
module ssr_status (
   input wire I_CLOCK,
   input wire I_SRST,
   input wire [15:0] I_OPER_COND,
   input wire [15:0] I_QUES_COND,
   input wire I_LANG_SAVED,
   input wire I_ERRQ_NONEMPTY,
   input wire I_OUTQ_AVAIL,
   input wire I_OPS_PENDING,
   input wire I_WR,
   input wire I_RD,
   input wire [3:0] I_SEL,
   input wire [15:0] I_WDATA,
   input wire I_CLS,
   input wire I_PRESET,
   input wire I_OPC,
   input wire I_ERR_VALID,
   input wire [15:0] I_ERR_CODE,
   input wire I_LANG_CMD,
   input wire I_LANG_LONG,
   input wire I_LANG_COLON,
   output reg [15:0] O_RDATA,
   output reg O_RVALID,
   output reg [7:0] O_STB,
   output reg O_MSS,
   output reg O_LANG_SCPI,
   output reg O_SYNTAX_ERR,
   output reg O_INST_RESET
);
   // synchroniser stages for pin inputs
   reg [15:0] oper_meta;
   reg [15:0] oper_cond;
   reg [15:0] ques_meta;
   reg [15:0] ques_cond;
   reg lang_meta;
   reg lang_sync;
   // standard event group, service request and boot state
   reg [7:0] esr;
   reg [7:0] ese;
   reg [7:0] sre;
   reg opc_armed;
   reg [1:0] boot_cnt;
   reg boot_done;
   // combinational next values
   reg [7:0] next_esr;
   reg [7:0] next_stb;
   reg [15:0] next_rdata;
   reg next_mss;
   reg [7:0] err_bits;
   wire oper_sum;
   wire ques_sum;
   wire [15:0] oper_rise;
   wire [15:0] oper_fall;
   wire [15:0] oper_event;
   wire [15:0] oper_enable;
   wire [15:0] ques_rise;
   wire [15:0] ques_fall;
   wire [15:0] ques_event;
   wire [15:0] ques_enable;
   wire esb_sum;
   wire opc_done;
   wire lang_bad;
   wire esr_query;
   wire signed [15:0] code;

   assign code = I_ERR_CODE;
   assign esb_sum = |(esr & ese);
   assign opc_done = opc_armed & ~I_OPS_PENDING;
   assign lang_bad = I_LANG_CMD & (I_LANG_LONG | I_LANG_COLON);
   assign esr_query = I_RD && (I_SEL == `SSR_SEL_ESR);

   // two-stage sync of the live status pins and language strap
   always @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         oper_meta <= 16'h0000;
         oper_cond <= 16'h0000;
         ques_meta <= 16'h0000;
         ques_cond <= 16'h0000;
         lang_meta <= 1'b0;
         lang_sync <= 1'b0;
      end
      else
      begin
         oper_meta <= I_OPER_COND;
         oper_cond <= oper_meta & `SSR_GRP_USED;
         ques_meta <= I_QUES_COND;
         ques_cond <= ques_meta & `SSR_GRP_USED;
         lang_meta <= I_LANG_SAVED;
         lang_sync <= lang_meta;
      end
   end

   // operational group
   ssr_group u_oper (
      .i_clk(I_CLOCK),
      .i_srst(I_SRST),
      .i_cond(oper_cond),
      .i_wr_rise(I_WR && (I_SEL == `SSR_SEL_OPER_RISE)),
      .i_wr_fall(I_WR && (I_SEL == `SSR_SEL_OPER_FALL)),
      .i_wr_enable(I_WR && (I_SEL == `SSR_SEL_OPER_ENABLE)),
      .i_wdata(I_WDATA),
      .i_rd_event(I_RD && (I_SEL == `SSR_SEL_OPER_EVENT)),
      .i_cls(I_CLS),
      .i_preset(I_PRESET),
      .o_rise(oper_rise),
      .o_fall(oper_fall),
      .o_event(oper_event),
      .o_enable(oper_enable),
      .o_summary(oper_sum)
   );

   // questionable group
   ssr_group u_ques (
      .i_clk(I_CLOCK),
      .i_srst(I_SRST),
      .i_cond(ques_cond),
      .i_wr_rise(I_WR && (I_SEL == `SSR_SEL_QUES_RISE)),
      .i_wr_fall(I_WR && (I_SEL == `SSR_SEL_QUES_FALL)),
      .i_wr_enable(I_WR && (I_SEL == `SSR_SEL_QUES_ENABLE)),
      .i_wdata(I_WDATA),
      .i_rd_event(I_RD && (I_SEL == `SSR_SEL_QUES_EVENT)),
      .i_cls(I_CLS),
      .i_preset(I_PRESET),
      .o_rise(ques_rise),
      .o_fall(ques_fall),
      .o_event(ques_event),
      .o_enable(ques_enable),
      .o_summary(ques_sum)
   );

   // classify a reported error code into its standard event bit
   always @*
   begin
      err_bits = 8'h00;
      if (I_ERR_VALID)
      begin
         if (code >= $signed(`SSR_QRY_LO) && code <= $signed(`SSR_QRY_HI))
            err_bits[`SSR_ESR_QRY] = 1'b1;
         if (code >= $signed(`SSR_DEV_LO) && code <= $signed(`SSR_DEV_HI))
            err_bits[`SSR_ESR_DEV] = 1'b1;
         if (code >= $signed(`SSR_DEVP_LO) && code <= $signed(`SSR_DEVP_HI))
            err_bits[`SSR_ESR_DEV] = 1'b1;
         if (code >= $signed(`SSR_EXE_LO) && code <= $signed(`SSR_EXE_HI))
            err_bits[`SSR_ESR_EXE] = 1'b1;
         if (code >= $signed(`SSR_CMD_LO) && code <= $signed(`SSR_CMD_HI))
            err_bits[`SSR_ESR_CMD] = 1'b1;
      end
      // a malformed language command counts as a command error
      if (lang_bad)
         err_bits[`SSR_ESR_CMD] = 1'b1;
      if (opc_done)
         err_bits[`SSR_ESR_OPC] = 1'b1;
   end

   // standard event register: query or clear-status empties it, sets win
   always @*
   begin
      next_esr = esr;
      if (esr_query || I_CLS)
         next_esr = 8'h00;
      next_esr = (next_esr | err_bits) & `SSR_ESR_USED;
   end

   // summary status byte and the master service summary
   always @*
   begin
      next_stb = 8'h00;
      next_stb[`SSR_STB_ERRQ] = I_ERRQ_NONEMPTY;
      next_stb[`SSR_STB_QUES] = ques_sum;
      next_stb[`SSR_STB_MAV] = I_OUTQ_AVAIL;
      next_stb[`SSR_STB_ESB] = esb_sum;
      next_stb[`SSR_STB_OPER] = oper_sum;
      // bit 6 itself is masked out so the summary cannot hold itself up
      next_mss = |(next_stb & sre & ~(8'h01 << `SSR_STB_MSS));
      next_stb[`SSR_STB_MSS] = next_mss;
   end

   // query data mux; unmapped selects read zero
   always @*
   begin
      next_rdata = 16'h0000;
      if (I_SEL == `SSR_SEL_OPER_COND)
         next_rdata = oper_cond;
      else if (I_SEL == `SSR_SEL_OPER_RISE)
         next_rdata = oper_rise;
      else if (I_SEL == `SSR_SEL_OPER_FALL)
         next_rdata = oper_fall;
      else if (I_SEL == `SSR_SEL_OPER_EVENT)
         next_rdata = oper_event;
      else if (I_SEL == `SSR_SEL_OPER_ENABLE)
         next_rdata = oper_enable;
      else if (I_SEL == `SSR_SEL_QUES_COND)
         next_rdata = ques_cond;
      else if (I_SEL == `SSR_SEL_QUES_RISE)
         next_rdata = ques_rise;
      else if (I_SEL == `SSR_SEL_QUES_FALL)
         next_rdata = ques_fall;
      else if (I_SEL == `SSR_SEL_QUES_EVENT)
         next_rdata = ques_event;
      else if (I_SEL == `SSR_SEL_QUES_ENABLE)
         next_rdata = ques_enable;
      else if (I_SEL == `SSR_SEL_ESR)
         next_rdata = {8'h00, esr};
      else if (I_SEL == `SSR_SEL_ESE)
         next_rdata = {8'h00, ese};
      else if (I_SEL == `SSR_SEL_STB)
         next_rdata = {8'h00, O_STB};
      else if (I_SEL == `SSR_SEL_SRE)
         next_rdata = {8'h00, sre};
   end

   // event, enable and operation-complete state
   always @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         esr <= `SSR_BYTE_RESET;
         ese <= `SSR_BYTE_RESET;
         sre <= `SSR_BYTE_RESET;
         opc_armed <= 1'b0;
      end
      else
      begin
         esr <= next_esr;
         if (I_WR && (I_SEL == `SSR_SEL_ESE))
            ese <= I_WDATA[7:0];
         if (I_WR && (I_SEL == `SSR_SEL_SRE))
            sre <= I_WDATA[7:0];
         // a fresh operation-complete request wins over clear-status
         if (I_OPC)
            opc_armed <= 1'b1;
         else if (I_CLS || opc_done)
            opc_armed <= 1'b0;
      end
   end

   // registered status outputs and query answer
   always @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         O_STB <= `SSR_BYTE_RESET;
         O_MSS <= 1'b0;
         O_RDATA <= 16'h0000;
         O_RVALID <= 1'b0;
      end
      else
      begin
         O_STB <= next_stb;
         O_MSS <= next_mss;
         O_RVALID <= I_RD;
         if (I_RD)
            O_RDATA <= next_rdata;
      end
   end

   // language select and power-up reset request
   always @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         O_LANG_SCPI <= 1'b0;
         O_SYNTAX_ERR <= 1'b0;
         O_INST_RESET <= 1'b0;
         boot_cnt <= 2'h0;
         boot_done <= 1'b0;
      end
      else
      begin
         O_SYNTAX_ERR <= lang_bad;
         O_INST_RESET <= 1'b0;
         if (!boot_done)
         begin
            // wait for the strap to pass the synchroniser, then take it
            if (boot_cnt == `SSR_BOOT_WAIT)
            begin
               boot_done <= 1'b1;
               O_LANG_SCPI <= lang_sync;
               O_INST_RESET <= lang_sync;
            end
            else
               boot_cnt <= boot_cnt + 2'h1;
         end
         else if (I_LANG_CMD && !lang_bad)
            O_LANG_SCPI <= 1'b1;
      end
   end
endmodule // ssr_status
`default_nettype wire

/* verification/ssr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
   input wire logic i_clk,
   input wire logic [15:0] i_rdata,
   output logic o_rd,
   output logic o_wr,
   output logic [3:0] o_sel,
   output logic [15:0] o_wdata
);
   // idle request lines from time zero
   initial
   begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_sel = 4'h0;
      o_wdata = 16'h0000;
   end
   // one write; data is scrambled afterwards so a stale value is never reused
   task automatic wr(input logic [3:0] sel, input logic [15:0] d);
   begin
      @(negedge i_clk);
      o_sel = sel;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_wdata = ~d;
   end
   endtask
   // query held for n edges; the answer to the last one is returned
   task automatic rd(input logic [3:0] sel, input int n, output logic [15:0] d);
   begin
      @(negedge i_clk);
      o_sel = sel;
      o_rd = 1'b1;
      repeat (n) @(negedge i_clk);
      o_rd = 1'b0;
      @(negedge i_clk);
      d = i_rdata;
   end
   endtask
endmodule // ssr_host
`default_nettype wire

/* verification/ssr_status_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_status_monitor (
   input wire logic I_CLOCK,
   input wire logic I_SRST,
   input wire logic I_ERRQ_NONEMPTY,
   input wire logic I_OUTQ_AVAIL,
   input wire logic I_RD,
   input wire logic [3:0] I_SEL,
   input wire logic I_ERR_VALID,
   input wire logic I_LANG_CMD,
   input wire logic I_LANG_LONG,
   input wire logic I_LANG_COLON,
   input wire logic [15:0] O_RDATA,
   input wire logic O_RVALID,
   input wire logic [7:0] O_STB,
   input wire logic O_MSS,
   input wire logic O_SYNTAX_ERR,
   input wire logic O_LANG_SCPI
);
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_SRST);
   // query of the standard event register, and one with no error report or language command beside it
   sequence esr_query;
      I_RD && I_SEL == 4'hA;
   endsequence
   sequence esr_quiet;
      esr_query ##0 (!I_ERR_VALID && !I_LANG_CMD);
   endsequence
   sequence bad_lang;
      I_LANG_CMD && (I_LANG_LONG || I_LANG_COLON);
   endsequence
   rvalid_pulse_a: assert property (O_RVALID == $past(I_RD))
      else $error("answer strobe not one cycle after query");
   stb_unused_a: assert property (O_STB[1:0] == 2'h0)
      else $error("summary byte low bits set");
   mss_copy_a: assert property (O_MSS == O_STB[6])
      else $error("service summary differs from byte bit");
   // the service summary needs some other byte bit behind it, never itself
   mss_cause_a: assert property (O_MSS |-> (O_STB & 8'hBF) != 8'h00)
      else $error("service summary set with no byte bit behind it");
   errq_bit_a: assert property ($past(I_ERRQ_NONEMPTY, 2) == $past(I_ERRQ_NONEMPTY)
      |-> O_STB[2] == $past(I_ERRQ_NONEMPTY)) else $error("error queue bit wrong");
   outq_bit_a: assert property ($past(I_OUTQ_AVAIL, 2) == $past(I_OUTQ_AVAIL)
      |-> O_STB[4] == $past(I_OUTQ_AVAIL)) else $error("output queue bit wrong");
   esr_unused_a: assert property (esr_query |=> O_RDATA[15:6] == 10'h000 && !O_RDATA[1])
      else $error("unused event bits set");
   esr_clear_a: assert property (esr_quiet ##1 esr_query |=> O_RDATA[7:1] == 7'h00)
      else $error("event register not cleared by query");
   bad_lang_a: assert property (bad_lang |=> O_SYNTAX_ERR)
      else $error("bad language form not flagged");
   lang_sel_a: assert property (I_LANG_CMD && !I_LANG_LONG && !I_LANG_COLON
      |=> O_LANG_SCPI && !O_SYNTAX_ERR) else $error("short language form not taken");
endmodule // ssr_status_monitor
bind ssr_status ssr_status_monitor ssr_status_monitor_inst (.I_CLOCK(I_CLOCK),
   .I_SRST(I_SRST), .I_ERRQ_NONEMPTY(I_ERRQ_NONEMPTY), .I_OUTQ_AVAIL(I_OUTQ_AVAIL),
   .I_RD(I_RD), .I_SEL(I_SEL), .I_ERR_VALID(I_ERR_VALID), .I_LANG_CMD(I_LANG_CMD),
   .I_LANG_LONG(I_LANG_LONG), .I_LANG_COLON(I_LANG_COLON), .O_RDATA(O_RDATA),
   .O_RVALID(O_RVALID), .O_STB(O_STB), .O_MSS(O_MSS), .O_SYNTAX_ERR(O_SYNTAX_ERR),
   .O_LANG_SCPI(O_LANG_SCPI));
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic clk, srst, lsaved, errq, outq, pend, cls, preset, opc, ev, lcmd, llong, lcolon;
   logic rd, wr, rvalid, master_service_summary, scpi, serr, ireset, seen;
   logic [3:0] sel;
   logic [7:0] stb;
   logic [15:0] ocond, qcond, ecode, wdata, rdata, d;
   int fail_count, cmp_count, cyc;
   logic [3:0] psel [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9};
   logic [15:0] pval [6] = '{16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
   logic [15:0] codes [13] = '{16'hFE0D, 16'hFE70, 16'hFE71, 16'hFED4, 16'h0001, 16'h7FFF,
      16'hFED5, 16'hFF38, 16'hFF39, 16'hFF9C, 16'hFF9D, 16'h0000, 16'hFE0C};
   logic [7:0] bits [13] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h20,
      8'h20, 8'h00, 8'h00, 8'h00};
   ssr_status ssr_status_inst (.I_CLOCK(clk), .I_SRST(srst), .I_OPER_COND(ocond),
      .I_QUES_COND(qcond), .I_LANG_SAVED(lsaved), .I_ERRQ_NONEMPTY(errq),
      .I_OUTQ_AVAIL(outq), .I_OPS_PENDING(pend), .I_WR(wr), .I_RD(rd), .I_SEL(sel),
      .I_WDATA(wdata), .I_CLS(cls), .I_PRESET(preset), .I_OPC(opc), .I_ERR_VALID(ev),
      .I_ERR_CODE(ecode), .I_LANG_CMD(lcmd), .I_LANG_LONG(llong), .I_LANG_COLON(lcolon),
      .O_RDATA(rdata), .O_RVALID(rvalid), .O_STB(stb), .O_MSS(master_service_summary), .O_LANG_SCPI(scpi),
      .O_SYNTAX_ERR(serr), .O_INST_RESET(ireset));
   ssr_host ssr_host_inst (.i_clk(clk), .i_rdata(rdata), .o_rd(rd), .o_wr(wr),
      .o_sel(sel), .o_wdata(wdata));
   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // reset for 8 cycles, watch the boot pulse, then check filter and enable values
   task automatic reset_check();
      srst = 1'b1;
      idle(8);
      srst = 1'b0;
      seen = 1'b0;
      repeat (8) @(negedge clk) if (ireset === 1'b1) seen = 1'b1;
      `CHK("boot pulse", lsaved, seen)
      for (int i = 0; i < 6; i++)
      begin
         ssr_host_inst.rd(psel[i], 1, d);
         `CHK("filter preset", pval[i], d)
      end
      $display("test reset done");
   endtask
   task automatic set_cond(input logic [3:0] b, input logic [15:0] v);
      @(negedge clk);
      if (b == 4'h0) ocond = v;
      else qcond = v;
      idle(6);
   endtask
   // one status group: filters, latching, summary and service bit
   task automatic group_test(input logic [3:0] b, input int sb);
      ssr_host_inst.wr(b + 4'h1, 16'h0001);
      ssr_host_inst.wr(b + 4'h2, 16'h0002);
      ssr_host_inst.wr(b + 4'h3, 16'hFFFF);
      ssr_host_inst.rd(b + 4'h1, 1, d);
      `CHK("rise filter", 16'h0001, d)
      ssr_host_inst.rd(b + 4'h2, 1, d);
      `CHK("fall filter", 16'h0002, d)
      set_cond(b, 16'h0002);
      set_cond(b, 16'h0001);
      ssr_host_inst.rd(b, 2, d);
      `CHK("condition", 16'h0001, d)
      set_cond(b, 16'h0000);
      ssr_host_inst.rd(b + 4'h3, 1, d);
      `CHK("event", 16'h0003, d)
      ssr_host_inst.rd(b + 4'h3, 1, d);
      `CHK("event after query", 16'h0000, d)
      ssr_host_inst.wr(b + 4'h4, 16'h0001);
      set_cond(b, 16'h0001);
      `CHK("summary bit", 1'b1, stb[sb])
      ssr_host_inst.wr(4'hD, 16'h0001 << sb);
      idle(2);
      `CHK("service bit", 1'b1, master_service_summary)
      pulse(cls);
      idle(3);
      `CHK("summary after clear", 2'b00, {stb[sb], master_service_summary})
      ssr_host_inst.rd(b + 4'h1, 1, d);
      `CHK("rise after clear", 16'h0001, d)
      ssr_host_inst.rd(b + 4'h4, 1, d);
      `CHK("enable", 16'h0001, d)
      ssr_host_inst.wr(4'hD, 16'h0000);
      set_cond(b, 16'h0000);
      $display("test group %0d done", b);
   endtask
   initial
   begin
      {srst, lsaved, errq, outq, pend, cls, preset, opc, ev, lcmd, llong, lcolon} = 12'h800;
      {ocond, qcond, ecode} = 48'h0000_0000_0000;
      fail_count = 0;
      cmp_count = 0;
      cyc = 0;
      reset_check();
      group_test(4'h0, 7);
      group_test(4'h5, 3);
      pulse(preset);
      for (int i = 0; i < 6; i++)
      begin
         ssr_host_inst.rd(psel[i], 1, d);
         `CHK("preset", pval[i], d)
      end
      ssr_host_inst.wr(4'hB, 16'h003D);
      ssr_host_inst.rd(4'hB, 1, d);
      `CHK("event enable", 16'h003D, d)
      for (int i = 0; i < 13; i++)
      begin
         @(negedge clk);
         ecode = codes[i];
         pulse(ev);
         idle(3);
         `CHK("event summary", bits[i] != 8'h00, stb[5])
         ssr_host_inst.rd(4'hA, 1, d);
         `CHK("error class", {8'h00, bits[i]}, d)
      end
      ssr_host_inst.rd(4'hA, 2, d);
      `CHK("event register empty", 16'h0000, d)
      pend = 1'b1;
      pulse(opc);
      idle(4);
      ssr_host_inst.rd(4'hA, 1, d);
      `CHK("completion early", 16'h0000, d)
      pend = 1'b0;
      idle(3);
      ssr_host_inst.rd(4'hA, 1, d);
      `CHK("completion", 16'h0001, d)
      {errq, outq} = 2'b11;
      idle(3);
      `CHK("queue bits", 4'h9, {stb[2], stb[1:0], stb[4]})
      ssr_host_inst.rd(4'hC, 1, d);
      `CHK("byte query", 16'h0014, d)
      {errq, outq} = 2'b00;
      idle(3);
      `CHK("queue bits idle", 2'b00, {stb[2], stb[4]})
      ssr_host_inst.rd(4'hE, 1, d);
      `CHK("unmapped", 16'h0000, d)
      $display("test events done");
      llong = 1'b1;
      pulse(lcmd);
      llong = 1'b0;
      lcolon = 1'b1;
      pulse(lcmd);
      lcolon = 1'b0;
      ssr_host_inst.rd(4'hA, 1, d);
      `CHK("syntax error", 16'h0020, d)
      `CHK("language kept", 1'b0, scpi)
      pulse(lcmd);
      idle(2);
      `CHK("language", 1'b1, scpi)
      lsaved = 1'b1;
      reset_check();
      `CHK("saved language", 1'b1, scpi)
      $display("test language done");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
